// file: ppa_loader.v
`include "ppa_consts.vh"

// Overview of operation
// [R1] Low read strobe puts ready/busy on bit7
// [R2] Rising write strobe latches one data byte
// [R3] Host ties unused read strobe high
// [R4] Flag high ready, low while busy
// [R5] Flag high at idle and before user
// [R6] Selected only when both chip selects active
// [R7] Host holds selects through config and init
// [R8] Unused chip select tied to active
// [R9] Config pins tri-state outside scheme, then user
// [R10] Startup clock option times initialization
// [R11] Disabled option pins act as user pins
// [R12] Init-done undriven during reset and start
// [R13] Init-done driven low once enabled
// [R14] Release init-done at end, enter user
// [R15] Monitor watches init-done rising edge
// [R16] Global output enable low tri-states pins
// [R17] Global clear low clears all registers
// [R18] Error pulls status line low
// [R19] All data good releases done, starts init
// [R20] Flag low after byte until processed
module ppa_loader (
    input wire mclk,
    input wire srst,
    input wire parallel_async_scheme,
    input wire [`PPA_BYTE_W-1:0] data_in,
    output wire [`PPA_BYTE_W-1:0] data_out,
    output wire [`PPA_BYTE_W-1:0] data_oe,
    input wire write_strobe_n,
    input wire read_strobe_n,
    input wire chip_select_low,
    input wire chip_select_high,
    output wire ready_busy_flag,
    output wire ready_busy_oe,
    input wire config_reset_n,
    input wire config_error_n_in,
    output wire config_error_n_out,
    output wire config_error_n_oe,
    input wire load_complete_in,
    output wire load_complete_out,
    output wire load_complete_oe,
    input wire [23:0] image_bytes,
    input wire startup_clock_en,
    input wire startup_clock_in,
    input wire init_done_pin_en,
    output wire init_done_out,
    output wire init_done_oe,
    input wire global_oe_en,
    input wire global_output_enable,
    input wire global_clear_en,
    input wire global_clear_n,
    input wire [`PPA_BYTE_W-1:0] user_out,
    input wire [`PPA_BYTE_W-1:0] user_oe,
    output wire [`PPA_BYTE_W-1:0] pin_out,
    output wire [`PPA_BYTE_W-1:0] pin_oe,
    output wire user_mode,
    output wire user_reg_clear,
    output reg [`PPA_BYTE_W-1:0] cfg_byte,
    output reg cfg_byte_valid,
    output wire [`PPA_BYTE_W-1:0] weak_pullup_en
);
    localparam ST_RESET = 3'h0;
    localparam ST_LOAD = 3'h1;
    localparam ST_INIT = 3'h2;
    localparam ST_USER = 3'h3;
    localparam ST_ERROR = 3'h4;

    // Cycle counts and header pattern cut to their register widths
    localparam integer PROC_CYC_I = `PPA_PROC_CYC;
    localparam integer INIT_CYC_I = `PPA_INIT_CYC;
    localparam [3:0] PROC_CYC = PROC_CYC_I[3:0];
    localparam [7:0] INIT_CYC = INIT_CYC_I[7:0];
    localparam [7:0] HDR_SYNC = `PPA_HDR_SYNC;

    // Synchronised pins
    wire [`PPA_BYTE_W-1:0] data_s;
    wire ws_n_s;
    wire rs_n_s;
    wire cs_l_s;
    wire cs_h_s;
    wire cfgrst_n_s;
    wire stat_in_s;
    wire done_in_s;
    wire uclk_s;
    wire goe_s;
    wire gclr_n_s;

    ppa_sync2 #(.W(`PPA_BYTE_W), .INIT(8'h00)) u_sync_data (
        .mclk(mclk),
        .srst(srst),
        .async_in(data_in),
        .sync_out(data_s)
    );

    ppa_sync2 #(.W(10), .INIT(10'h3f9)) u_sync_ctl ( // Start-up clock idles low
        .mclk(mclk),
        .srst(srst),
        .async_in({write_strobe_n, read_strobe_n, chip_select_low, chip_select_high,
            config_reset_n, config_error_n_in, load_complete_in, startup_clock_in,
            global_output_enable, global_clear_n}),
        .sync_out({ws_n_s, rs_n_s, cs_l_s, cs_h_s, cfgrst_n_s, stat_in_s,
            done_in_s, uclk_s, goe_s, gclr_n_s})
    );

    reg [2:0] st_q;
    reg [2:0] st_d;
    reg ws_prev_q;
    reg uclk_prev_q;
    reg busy_q;
    reg [3:0] proc_q;
    reg [23:0] cnt_q;
    reg hdr_seen_q;
    reg init_done_en_q;
    reg [7:0] init_q;
    reg err_q;
    reg [3:0] pend_q;

    wire selected;
    wire ws_rise;
    wire init_tick;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [`PPA_BYTE_W-1:0] fifo_out_data;
    wire proc_take;
    wire loading;
    wire ppa_cfg;
    wire wr_req;
    wire fifo_wr;
    wire hdr_take;
    wire hdr_ok;

    // Select qualification
    assign selected = !cs_l_s && cs_h_s; // [R6]
    assign ws_rise = !ws_prev_q && ws_n_s; // [R2]
    assign loading = (st_q == ST_LOAD);
    assign ppa_cfg = parallel_async_scheme && loading;

    // Write request, accepted write and header byte check
    assign wr_req = ppa_cfg && selected && ws_rise; // [R2]
    assign fifo_wr = wr_req && fifo_in_ready;
    assign hdr_take = proc_take && !hdr_seen_q;
    assign hdr_ok = (fifo_out_data[7:1] == HDR_SYNC[7:1]);

    // Init timing source: startup clock edges or core cycles
    assign init_tick = startup_clock_en ? (uclk_s && !uclk_prev_q) : 1'b1; // [R10]

    // Byte buffer between pin capture and processing
    ppa_fifo #(.W(`PPA_BYTE_W), .DEPTH(`PPA_FIFO_DEPTH), .AW(`PPA_FIFO_AW)) u_fifo (
        .mclk(mclk),
        .srst(srst),
        .in_valid(wr_req), // [R2]
        .in_ready(fifo_in_ready),
        .in_data(data_s),
        .out_valid(fifo_out_valid),
        .out_ready(proc_take),
        .out_data(fifo_out_data)
    );

    // Processing takes a byte once the previous one is finished
    assign proc_take = fifo_out_valid && (proc_q == 4'h0);

    // Next state
    always @* begin
        st_d = st_q;
        case (st_q)
            ST_RESET: begin
                if (cfgrst_n_s) begin
                    st_d = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (err_q || !stat_in_s) begin
                    st_d = ST_ERROR; // [R18]
                end else if (hdr_seen_q && cnt_q == image_bytes && !busy_q
                        && !fifo_out_valid) begin
                    st_d = ST_INIT; // [R19]
                end
            end
            ST_INIT: begin
                if (!stat_in_s) begin
                    st_d = ST_ERROR;
                end else if (init_q == INIT_CYC && done_in_s) begin
                    st_d = ST_USER; // [R14]
                end
            end
            ST_USER: st_d = ST_USER;
            ST_ERROR: st_d = ST_ERROR;
            default: st_d = ST_RESET;
        endcase
        if (!cfgrst_n_s) begin
            st_d = ST_RESET;
        end
    end

    // State register and edge history of the synced write strobe and start-up clock
    always @(posedge mclk) begin
        if (srst) begin
            st_q <= ST_RESET;
            ws_prev_q <= 1'b1;
            uclk_prev_q <= 1'b0;
        end else begin
            st_q <= st_d;
            ws_prev_q <= ws_n_s;
            uclk_prev_q <= uclk_s;
        end
    end

    // Bytes written to the buffer but not yet taken for processing
    always @(posedge mclk) begin
        if (srst) begin
            pend_q <= 4'h0;
        end else if (fifo_wr && !proc_take) begin
            pend_q <= pend_q + 4'h1;
        end else if (proc_take && !fifo_wr) begin
            pend_q <= pend_q - 4'h1;
        end
    end

    // Busy from write edge until buffer drained and last byte processed
    always @(posedge mclk) begin
        if (srst) begin
            busy_q <= 1'b0;
            err_q <= 1'b0;
        end else if (st_q == ST_RESET) begin
            busy_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            if (wr_req) begin
                busy_q <= 1'b1; // [R20]
            end else if (pend_q == 4'h0 && proc_q == 4'h0) begin
                busy_q <= 1'b0;
            end
            if (wr_req && !fifo_in_ready) begin
                err_q <= 1'b1; // Overrun [R18]
            end else if (hdr_take && !hdr_ok) begin
                err_q <= 1'b1; // Bad header [R18]
            end
        end
    end

    // Byte processing: hand-off, option capture and byte count
    always @(posedge mclk) begin
        if (srst) begin
            proc_q <= 4'h0;
            cnt_q <= `PPA_CNT_RST;
            hdr_seen_q <= 1'b0;
            init_done_en_q <= 1'b0;
            cfg_byte <= 8'h00;
            cfg_byte_valid <= 1'b0;
        end else begin
            cfg_byte_valid <= proc_take;
            if (proc_take) begin
                proc_q <= PROC_CYC;
                cfg_byte <= fifo_out_data;
            end else if (proc_q != 4'h0) begin
                proc_q <= proc_q - 4'h1;
            end
            if (st_q == ST_RESET) begin
                cnt_q <= `PPA_CNT_RST;
                hdr_seen_q <= 1'b0;
                init_done_en_q <= 1'b0; // [R12]
            end else if (proc_take) begin
                cnt_q <= cnt_q + 24'h000001;
                if (!hdr_seen_q) begin
                    hdr_seen_q <= 1'b1;
                    init_done_en_q <= init_done_pin_en
                        && fifo_out_data[`PPA_OPT_INITDONE_BIT]; // [R13]
                end
            end
        end
    end

    // Initialization tick counter, saturating at the programmed length
    always @(posedge mclk) begin
        if (srst) begin
            init_q <= 8'h00;
        end else if (st_q == ST_RESET) begin
            init_q <= 8'h00;
        end else if (st_q == ST_INIT && init_tick && init_q != INIT_CYC) begin
            init_q <= init_q + 8'h01; // [R10]
        end
    end

    // Ready/busy on its own pin and on the top data bit under read strobe
    assign ready_busy_flag = !busy_q; // [R4] [R5]
    assign ready_busy_oe = parallel_async_scheme && (st_q != ST_USER); // [R5] [R9]
    assign data_out = {ready_busy_flag, 7'h00};
    assign data_oe = {ppa_cfg && !rs_n_s, 7'h00}; // [R1]

    // Open-drain status lines
    assign config_error_n_out = 1'b0;
    assign config_error_n_oe = (st_q == ST_ERROR); // [R18]
    assign load_complete_out = 1'b0;
    assign load_complete_oe = (st_q == ST_RESET) || loading; // [R19]
    assign init_done_out = 1'b0;
    assign init_done_oe = init_done_en_q && (loading || st_q == ST_INIT); // [R12] [R13] [R14]

    // User-mode pin steering with global output enable
    assign user_mode = (st_q == ST_USER); // [R14]
    assign pin_out = user_out;
    assign pin_oe = (user_mode && (!global_oe_en || goe_s)) ? user_oe : 8'h00; // [R16] [R9]
    assign weak_pullup_en = user_mode ? 8'h00 : 8'hff; // [R11]
    assign user_reg_clear = user_mode && global_clear_en && !gclr_n_s; // [R17]
endmodule

// file: ppa_consts.vh
`ifndef PPA_CONSTS_VH
`define PPA_CONSTS_VH

// Byte lane positions
`define PPA_TOP_BIT 7
`define PPA_BYTE_W 8

// Fifo sizing
`define PPA_FIFO_DEPTH 8
`define PPA_FIFO_AW 3

// Frame layout: first byte of the stream carries option bits
`define PPA_OPT_INITDONE_BIT 0
`define PPA_HDR_SYNC 8'h6a

// Timing: byte processing time in ns and its cycle count at 20 ns
`define PPA_CLK_NS 20
`define PPA_PROC_NS 100
`define PPA_PROC_CYC ((`PPA_PROC_NS + `PPA_CLK_NS - 1) / `PPA_CLK_NS)

// Initialization length in start-up clock edges or core cycles
`define PPA_INIT_CYC 16

// Reset values
`define PPA_CNT_RST 24'h000000

`endif

// file: ppa_sync2.v
module ppa_sync2 #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b1}}
) (
    input wire mclk,
    input wire srst,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);
    reg [W-1:0] meta_q;

    // Two-stage synchroniser; first stage read only by second
    always @(posedge mclk) begin
        if (srst) begin
            meta_q <= INIT;
            sync_out <= INIT;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// file: ppa_fifo.v
module ppa_fifo #(
    parameter W = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire mclk,
    input wire srst,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output reg out_valid,
    input wire out_ready,
    output reg [W-1:0] out_data
);
    reg [W-1:0] mem_q [0:DEPTH-1];
    reg [AW:0] wp_q;
    reg [AW:0] rp_q;
    wire empty;
    wire full;
    wire do_wr;
    wire do_rd;

    // Pointer comparison with wrap bit
    assign empty = (wp_q == rp_q);
    assign full = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
    assign in_ready = !full;
    assign do_wr = in_valid && !full;
    assign do_rd = !empty && (!out_valid || out_ready);

    // Storage write
    always @(posedge mclk) begin
        if (do_wr) begin
            mem_q[wp_q[AW-1:0]] <= in_data;
        end
    end

    // Pointers and registered read port
    always @(posedge mclk) begin
        if (srst) begin
            wp_q <= {(AW+1){1'b0}};
            rp_q <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data <= {W{1'b0}};
        end else begin
            if (do_wr) begin
                wp_q <= wp_q + 1'b1;
            end
            if (do_rd) begin
                out_data <= mem_q[rp_q[AW-1:0]];
                rp_q <= rp_q + 1'b1;
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule

// file: ppa_loader_asserts.sv
module ppa_loader_chk (
    input wire logic mclk,
    input wire logic srst,
    input wire logic parallel_async_scheme,
    input wire logic [7:0] data_out,
    input wire logic [7:0] data_oe,
    input wire logic read_strobe_n,
    input wire logic ready_busy_flag,
    input wire logic ready_busy_oe,
    input wire logic init_done_oe,
    input wire logic load_complete_oe,
    input wire logic global_oe_en,
    input wire logic global_output_enable,
    input wire logic [7:0] pin_oe,
    input wire logic user_mode,
    input wire logic cfg_byte_valid,
    input wire logic [7:0] weak_pullup_en
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // Flag path and busy window
    flag_on_bit7_a: assert property (data_oe[7] |->
        data_out[7] == ready_busy_flag && !$past(read_strobe_n, 2))
        else $error("flag missing on bit 7");
    ready_at_start_a: assert property ($fell(srst) |-> ready_busy_flag)
        else $error("flag low after reset");
    busy_on_byte_a: assert property (cfg_byte_valid |-> !ready_busy_flag)
        else $error("flag high while byte in work");
    // Pins handed back to the user
    user_pins_a: assert property (user_mode |-> !ready_busy_oe && data_oe == 8'h00)
        else $error("config pins driven in user mode");
    scheme_off_a: assert property (!parallel_async_scheme |-> !ready_busy_oe && !data_oe[7])
        else $error("config pins driven outside scheme");
    init_release_a: assert property ($rose(user_mode) |-> !init_done_oe && !load_complete_oe)
        else $error("status lines held at user entry");
    pullup_cfg_a: assert property (!user_mode |-> weak_pullup_en == 8'hff)
        else $error("pull-ups off during config");
    global_oe_a: assert property ((global_oe_en && !global_output_enable) [*4] |-> pin_oe == 8'h00)
        else $error("pins driven while globally disabled");
    // Main scenarios
    cover property ($rose(user_mode));
    cover property (cfg_byte_valid);
    cover property (data_oe[7] && !ready_busy_flag);
endmodule

bind ppa_loader ppa_loader_chk ppa_loader_chk_i (
    .mclk, .srst, .parallel_async_scheme, .data_out, .data_oe, .read_strobe_n, .ready_busy_flag,
    .ready_busy_oe, .init_done_oe, .load_complete_oe, .global_oe_en, .global_output_enable,
    .pin_oe, .user_mode, .cfg_byte_valid, .weak_pullup_en
);

// file: ppa_host.sv
module ppa_host (
    input wire logic mclk,
    input wire logic [7:0] data_out,
    input wire logic [7:0] data_oe,
    output logic [7:0] data_in,
    output logic write_strobe_n,
    output logic read_strobe_n,
    output logic chip_select_low,
    output logic chip_select_high
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle levels: selects active, strobes high
    initial begin
        data_in = 8'h00;
        write_strobe_n = 1'b1;
        read_strobe_n = 1'b1;
        chip_select_low = 1'b0;
        chip_select_high = 1'b1;
    end
    // Step off the edge after n clocks
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    // Select levels
    task automatic sel(input logic lo, input logic hi);
        chip_select_low = lo;
        chip_select_high = hi;
    endtask
    // One byte strobed in, then flag polled on bit 7
    task automatic put(input logic [7:0] b, output logic late);
        data_in = b;
        tick(3);
        write_strobe_n = 1'b0;
        tick(3);
        write_strobe_n = 1'b1;
        tick(5);
        data_in = ~b; // Released lines stop showing the byte
        read_strobe_n = 1'b0;
        late = 1'b1;
        for (int i = 0; i < 100 && late; i++) begin
            tick(1);
            late = !(data_oe[7] === 1'b1 && data_out[7] === 1'b1);
        end
        read_strobe_n = 1'b1;
    endtask
endmodule

// file: ppa_loader_tb.sv
module ppa_loader_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, srst, parallel_async_scheme, write_strobe_n, read_strobe_n, chip_select_low;
    logic chip_select_high, ready_busy_flag, ready_busy_oe, config_reset_n, config_error_n_out;
    logic config_error_n_oe, load_complete_out, load_complete_oe, startup_clock_en;
    logic startup_clock_in, init_done_pin_en, init_done_out, init_done_oe, global_oe_en;
    logic global_output_enable, global_clear_en, global_clear_n, user_mode, user_reg_clear;
    logic cfg_byte_valid, err_drv, late;
    logic [7:0] data_in, data_out, data_oe, user_out, user_oe, pin_out, pin_oe, cfg_byte;
    logic [7:0] weak_pullup_en;
    logic [23:0] image_bytes;
    wire config_error_n_in = !config_error_n_oe && !err_drv; // Pulled-up lines
    wire load_complete_in = !load_complete_oe;
    int error_cnt = 0;
    int comparisons = 0;
    logic [7:0] got[$];

    ppa_loader ppa_loader_i (.*);
    ppa_host ppa_host_i (.*);

    // Clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // Collect processed bytes
    always @(posedge mclk) begin
        if (cfg_byte_valid === 1'b1) begin
            got.push_back(cfg_byte);
            chk1(ready_busy_flag, 1'b0);
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    task automatic bump(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        bump(g, e);
    endtask
    task automatic chk1(input logic g, input logic e);
        bump({7'h00, g}, {7'h00, e});
    endtask
    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic send(input logic [7:0] b);
        ppa_host_i.put(b, late);
        if (late !== 1'b0) begin
            error_cnt++;
            finish_test;
        end
    endtask
    task automatic wait_um(input int n);
        int i;
        for (i = 0; i < n && user_mode !== 1'b1; i++) step(1);
        if (user_mode !== 1'b1) begin
            error_cnt++;
            finish_test;
        end
    endtask
    task automatic restart;
        config_reset_n = 1'b0;
        step(4);
        chk1(init_done_oe, 1'b0);
        config_reset_n = 1'b1;
        step(6);
        got.delete();
    endtask
    // Header then three image bytes
    task automatic load(input logic [7:0] hdr);
        send(hdr);
        chk1(init_done_oe, hdr[0] & init_done_pin_en);
        for (int i = 1; i < 4; i++) begin
            send(8'(i * 8'h11));
        end
        chk8(got[$], 8'h33);
        chk8(got[$-1], 8'h22);
    endtask

    // Scenarios
    task automatic t_unsel;
        ppa_host_i.sel(1'b1, 1'b1);
        send(8'h6b);
        chk8(8'(got.size()), 8'h00);
        ppa_host_i.sel(1'b0, 1'b1);
        $display("unselected strobe done");
    endtask
    task automatic t_load;
        load(8'h6b);
        chk1(init_done_oe, 1'b1);
        wait_um(100);
        chk1(init_done_oe, 1'b0);
        chk1(load_complete_oe, 1'b0);
        chk1(ready_busy_oe, 1'b0);
        chk8(weak_pullup_en, 8'h00);
        $display("full load done");
    endtask
    task automatic t_global;
        chk8(pin_out, 8'h5a);
        chk8(pin_oe, 8'hff);
        global_output_enable = 1'b0;
        step(4);
        chk8(pin_oe, 8'h00);
        global_oe_en = 1'b0;
        step(1);
        chk8(pin_oe, 8'hff);
        global_oe_en = 1'b1;
        global_output_enable = 1'b1;
        global_clear_n = 1'b0;
        step(4);
        chk1(user_reg_clear, 1'b1);
        global_clear_en = 1'b0;
        step(1);
        chk1(user_reg_clear, 1'b0);
        global_clear_en = 1'b1;
        global_clear_n = 1'b1;
        step(4);
        chk1(user_reg_clear, 1'b0);
        chk8(pin_oe, 8'hff);
        $display("global pins done");
    endtask
    task automatic t_suclk;
        restart;
        chk8(weak_pullup_en, 8'hff);
        startup_clock_en = 1'b1;
        init_done_pin_en = 1'b0;
        load(8'h6a);
        step(60);
        chk1(user_mode, 1'b0);
        repeat (20) begin
            step(3);
            startup_clock_in = 1'b1;
            step(3);
            startup_clock_in = 1'b0;
        end
        wait_um(50);
        $display("start-up clock done");
    endtask
    task automatic t_error;
        init_done_pin_en = 1'b1;
        restart;
        send(8'h6b);
        err_drv = 1'b1;
        step(4);
        err_drv = 1'b0;
        step(4);
        chk1(config_error_n_oe, 1'b1);
        chk1(user_mode, 1'b0);
        parallel_async_scheme = 1'b0;
        restart;
        chk1(config_error_n_oe, 1'b0);
        chk1(init_done_oe, 1'b0);
        chk1(ready_busy_oe, 1'b0);
        $display("error and scheme off done");
    endtask

    // Main sequence
    initial begin
        {srst, parallel_async_scheme, config_reset_n, init_done_pin_en} = 4'hf;
        {global_oe_en, global_output_enable, global_clear_en, global_clear_n} = 4'hf;
        {err_drv, startup_clock_en, startup_clock_in} = 3'h0;
        user_out = 8'h5a;
        user_oe = 8'hff;
        image_bytes = 24'h000004;
        step(10);
        chk1(ready_busy_flag, 1'b1);
        chk1(load_complete_oe, 1'b1);
        srst = 1'b0;
        step(6);
        t_unsel;
        t_load;
        t_global;
        t_suclk;
        t_error;
        finish_test;
    end
endmodule
